// [hdl/reset_sequencer.sv]
`timescale 1ns/1ps
`include "rstseq_map.svh"
// Reset sequencer with interrupt-pin and mode-pin reset behaviour
module reset_sequencer
  import rstseq_pkg::*;
#(
  parameter int OSC_DELAY = `OSC_DELAY_CYC
) (
  input  wire logic        core_clk,       // 50 MHz clock
  input  wire logic        rst,            // Power-on reset, sync high
  input  wire logic        wdogTimeout,    // Watchdog timer expiry
  input  wire logic        wdogEn,         // Watchdog enabled
  input  wire logic        clkFail,        // Clock monitor failure
  input  wire logic        clkMonEn,       // Clock monitor enabled
  input  wire logic        resetPinIn,     // Reset pin level
  output logic             resetPinOut,    // Reset pin drive value
  output logic             resetPinOeN,    // Low while driving pin
  output logic             coreReset,      // Core held in reset
  output logic [15:0]      vectorAddr,     // Fetch vector
  input  wire logic        maskIntPinIn,   // Maskable request pin
  input  wire logic        nmiPinIn,       // Nonmaskable request pin
  output logic             pullupOn,       // Pull-ups on request pins
  input  wire logic        modeSelA,       // Mode pin a
  input  wire logic        modeSelB,       // Mode pin b
  input  wire logic        specialModeN,   // Special mode select, active low
  output logic             modePulldown,   // Pull-downs on lower mode pins
  output logic [2:0]       opMode,         // Latched operating mode
  output logic             maskIntReq,     // Maskable request to core
  output logic             nmiReq,         // Nonmaskable request to core
  input  wire logic        intAck,         // Core acknowledges request
  input  wire logic [3:0]  regAddr,        // Register address
  input  wire logic [7:0]  regWdata,       // Write data
  input  wire logic        regWr,          // Write strobe
  input  wire logic        regRd,          // Read strobe
  output logic [7:0]       regRdata        // Read data, one cycle later
);
  localparam int CNT_W = $clog2(OSC_DELAY + 1) + 1;

  // The shared counter must also reach the recovery count, so tiny delays are refused
  if (OSC_DELAY < 4) begin
    $error("OSC_DELAY must be at least four");
  end

  // Async entry is modelled by immediate combinational pin drive
  logic       pinSync;
  logic       irqSync;
  logic       nmiSync;
  logic [2:0] modeSync;

  sync_2ff #(.WIDTH(1), .INIT(1'b0)) u_pin_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .din      (resetPinIn),
    .dout     (pinSync)
  );
  sync_2ff #(.WIDTH(5), .INIT(5'h03)) u_misc_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .din      ({modeSelA, modeSelB, specialModeN, maskIntPinIn, nmiPinIn}),
    .dout     ({modeSync, irqSync, nmiSync})
  );

  function automatic logic [15:0] pickVector(input logic pinHigh, input logic cm,
                                             input logic wd);
    if (!pinHigh) pickVector = `VEC_NORMAL;
    else if (cm) pickVector = `VEC_CLKMON;
    else if (wd) pickVector = `VEC_WDOG;
    else pickVector = `VEC_NORMAL;
  endfunction

  seq_state_type     state_ff, nxt_state;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic              cmLatch_ff, nxt_cmLatch;
  logic              wdLatch_ff, nxt_wdLatch;
  logic [15:0]       vector_ff, nxt_vector;
  logic [2:0]        mode_ff, nxt_mode;
  logic              wdEvent;
  logic              cmEvent;
  logic              extEvent;

  assign wdEvent  = wdogEn && wdogTimeout;
  assign cmEvent  = clkMonEn && clkFail;
  assign extEvent = (state_ff == SEQ_RUN) && !pinSync;

  // Sequencer: any source restarts from run; clock failure adds the startup delay
  always_comb begin
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_cmLatch = cmLatch_ff || cmEvent;
    nxt_wdLatch = wdLatch_ff || wdEvent;
    nxt_vector  = vector_ff;
    nxt_mode    = mode_ff;
    case (state_ff)
      SEQ_OSC: begin
        if (cnt_ff >= CNT_W'(OSC_DELAY - 1)) begin
          nxt_state = SEQ_LOW;
          nxt_cnt   = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      SEQ_LOW: begin
        nxt_mode = modeSync;
        if (cnt_ff >= CNT_W'(`RECOVER_LOW_CYC - 1)) begin
          nxt_state = SEQ_WAIT;
          nxt_cnt   = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      SEQ_WAIT: begin
        if (cnt_ff >= CNT_W'(`SAMPLE_DLY_CYC - 1)) begin
          nxt_state  = SEQ_RUN;
          nxt_cnt    = '0;
          nxt_vector = pickVector(pinSync, cmLatch_ff, wdLatch_ff);
          // Cleared on decision, but an event in this very cycle wins
          nxt_cmLatch = cmEvent;
          nxt_wdLatch = wdEvent;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      default: begin
        if (cmEvent) begin
          nxt_state = SEQ_OSC;
          nxt_cnt   = '0;
        end else if (wdEvent || extEvent) begin
          nxt_state = SEQ_LOW;
          nxt_cnt   = '0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff   <= SEQ_OSC;
      cnt_ff     <= '0;
      cmLatch_ff <= 1'b0;
      wdLatch_ff <= 1'b0;
      vector_ff  <= `VEC_NORMAL;
      mode_ff    <= 3'h0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      cmLatch_ff <= nxt_cmLatch;
      wdLatch_ff <= nxt_wdLatch;
      vector_ff  <= nxt_vector;
      mode_ff    <= nxt_mode;
    end
  end

  // Drive low at once on power-on, watchdog or clock failure, even with no clock edge
  logic driveLow;
  assign driveLow    = rst || cmEvent || wdEvent
                       || (state_ff == SEQ_OSC) || (state_ff == SEQ_LOW);
  assign resetPinOut = 1'b0;
  assign resetPinOeN = !driveLow;
  assign coreReset   = rst || (state_ff != SEQ_RUN);
  assign modePulldown = coreReset;
  assign vectorAddr  = vector_ff;
  assign opMode      = mode_ff;

  // Control registers, reset whenever the core is in reset
  logic [7:0] intCtrl_ff, nxt_intCtrl;
  logic [7:0] pullCtrl_ff, nxt_pullCtrl;
  logic [7:0] ccode_ff, nxt_ccode;
  logic [7:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_intCtrl  = intCtrl_ff;
    nxt_pullCtrl = pullCtrl_ff;
    nxt_ccode    = ccode_ff;
    nxt_rdata    = 8'h00;
    if (coreReset) begin
      nxt_intCtrl  = `INT_CTRL_RST;
      nxt_pullCtrl = `PULLUP_CTRL_RST;
      nxt_ccode    = `COND_CODE_RST;
    end else if (regWr) begin
      if (regAddr == `ADDR_INT_CTRL) nxt_intCtrl = regWdata;
      else if (regAddr == `ADDR_PULLUP_CTRL) nxt_pullCtrl = regWdata;
      else if (regAddr == `ADDR_COND_CODE) begin
        nxt_ccode = regWdata;
        // Nonmaskable mask may be cleared but never set again by software
        nxt_ccode[`CC_X_BIT] = ccode_ff[`CC_X_BIT] & regWdata[`CC_X_BIT];
      end
    end
    if (regRd) begin
      if (regAddr == `ADDR_INT_CTRL) nxt_rdata = intCtrl_ff;
      else if (regAddr == `ADDR_PULLUP_CTRL) nxt_rdata = pullCtrl_ff;
      else if (regAddr == `ADDR_COND_CODE) nxt_rdata = ccode_ff;
      else if (regAddr == `ADDR_STATUS)
        nxt_rdata = {3'h0, irqSync, nmiSync, cmLatch_ff, wdLatch_ff, coreReset};
      else if (regAddr == `ADDR_MODE) nxt_rdata = {5'h00, mode_ff};
      else nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      intCtrl_ff  <= `INT_CTRL_RST;
      pullCtrl_ff <= `PULLUP_CTRL_RST;
      ccode_ff    <= `COND_CODE_RST;
      rdata_ff    <= 8'h00;
    end else begin
      intCtrl_ff  <= nxt_intCtrl;
      pullCtrl_ff <= nxt_pullCtrl;
      ccode_ff    <= nxt_ccode;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign regRdata = rdata_ff;
  assign pullupOn = coreReset || pullCtrl_ff[`PULLUP_EN_BIT];

  irq_detect u_irq (
    .core_clk (core_clk),
    .rst      (coreReset),
    .irqLvlN  (irqSync),
    .edgeMode (intCtrl_ff[`INT_CTRL_EDGE]),
    .enable   (intCtrl_ff[`INT_CTRL_EN]),
    .masked   (ccode_ff[`CC_I_BIT]),
    .ack      (intAck),
    .req      (maskIntReq)
  );

  // Level-sensitive nonmaskable request, held while line low and unmasked
  assign nmiReq = !coreReset && !ccode_ff[`CC_X_BIT] && !nmiSync;

  // Checker helper: cycles spent so far in the startup delay, too long for a repetition
  logic [CNT_W-1:0] oscSeen_ff, nxt_oscSeen;

  always_comb begin
    nxt_oscSeen = '0;
    if (state_ff == SEQ_OSC) nxt_oscSeen = oscSeen_ff + 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      oscSeen_ff <= '0;
    end else begin
      oscSeen_ff <= nxt_oscSeen;
    end
  end

  // Vector choice at the sampling point; a clock failure in that cycle stays latched
  property p_ext_vector;
    @(posedge core_clk) disable iff (rst)
    (state_ff == SEQ_WAIT && cnt_ff == CNT_W'(`SAMPLE_DLY_CYC - 1) && !pinSync)
      |=> (vector_ff == `VEC_NORMAL && (!cmLatch_ff || $past(cmEvent)));
  endproperty
  a_ext_vector: assert property (p_ext_vector)
    else $error("external reset vector wrong");
  property p_cm_vector;
    @(posedge core_clk) disable iff (rst)
    (state_ff == SEQ_WAIT && cnt_ff == CNT_W'(`SAMPLE_DLY_CYC - 1) && pinSync && cmLatch_ff)
      |=> vector_ff == `VEC_CLKMON;
  endproperty
  a_cm_vector: assert property (p_cm_vector)
    else $error("clock monitor vector wrong");
  property p_wd_vector;
    @(posedge core_clk) disable iff (rst)
    (state_ff == SEQ_WAIT && cnt_ff == CNT_W'(`SAMPLE_DLY_CYC - 1) && pinSync
      && !cmLatch_ff && wdLatch_ff) |=> vector_ff == `VEC_WDOG;
  endproperty
  a_wd_vector: assert property (p_wd_vector)
    else $error("watchdog vector wrong");
  // Sixteen driven cycles, split in two short repetitions
  property p_low_len;
    @(posedge core_clk) disable iff (rst || cmEvent || wdEvent)
    $rose(state_ff == SEQ_LOW) |->
      (!resetPinOeN)[*8] ##1 (!resetPinOeN)[*8] ##1 (state_ff == SEQ_WAIT);
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("recovery low length wrong");
  property p_wait_release;
    @(posedge core_clk) disable iff (rst || cmEvent || wdEvent)
    $rose(state_ff == SEQ_WAIT) |-> resetPinOeN[*8] ##1 resetPinOeN;
  endproperty
  a_wait_release: assert property (p_wait_release)
    else $error("pin driven during wait");
  // Events inside the sequence only latch, so the restart is checked from run
  property p_src_drive;
    @(posedge core_clk) disable iff (rst)
    (state_ff == SEQ_RUN && (wdEvent || cmEvent)) |-> !resetPinOeN ##1 !resetPinOeN;
  endproperty
  a_src_drive: assert property (p_src_drive)
    else $error("source did not drive pin");
  property p_reset_ccr;
    @(posedge core_clk) disable iff (rst)
    coreReset |=> (ccode_ff[`CC_X_BIT] && ccode_ff[`CC_I_BIT] && intCtrl_ff[`INT_CTRL_EN]);
  endproperty
  a_reset_ccr: assert property (p_reset_ccr)
    else $error("reset masks not set");
  property p_osc_bound;
    @(posedge core_clk) disable iff (rst)
    (state_ff == SEQ_OSC) |-> (!resetPinOeN && oscSeen_ff < CNT_W'(OSC_DELAY));
  endproperty
  a_osc_bound: assert property (p_osc_bound)
    else $error("startup delay overran");
  property p_osc_exit;
    @(posedge core_clk) disable iff (rst)
    (state_ff == SEQ_OSC && oscSeen_ff == CNT_W'(OSC_DELAY - 1)) |=> (state_ff == SEQ_LOW);
  endproperty
  a_osc_exit: assert property (p_osc_exit)
    else $error("startup delay not ended");
  property p_pullup;
    @(posedge core_clk) disable iff (rst)
    coreReset |-> pullupOn;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up off in reset");

  c_cm: cover property (@(posedge core_clk) vector_ff == `VEC_CLKMON);
  c_wd: cover property (@(posedge core_clk) vector_ff == `VEC_WDOG);
  c_ext: cover property (@(posedge core_clk) extEvent);
  c_irq: cover property (@(posedge core_clk) maskIntReq);
endmodule

// [hdl/rstseq_map.svh]
// Notes on behaviour
// - Reset starts on power-on, watchdog timeout, clock failure or low reset pin.
// - Entry into reset is asynchronous; exit from reset is clocked.
// - Any reset source drives the reset pin low; a clocked sequence controls release.
// - Power-on or clock failure holds the pin low 4096 cycles first; a clock failure during the sequence only latches, with no startup delay.
// - Recovery drives the pin low 16 to 17 cycles, then releases it.
// - Nine cycles after release, low pin means external reset; clear latches, normal vector.
// - High pin with clock failure latched selects the clock-monitor vector.
// - High pin, no clock failure, watchdog latched selects the watchdog vector.
// - High pin with nothing pending selects the normal reset vector.
// - Maskable request selects falling-edge or level trigger by software.
// - Maskable input is enabled and level triggered after reset; software may disable.
// - Reset sets the maskable mask until software clears it.
// - Both request pins readable; pull-ups on at reset until software turns them off.
// - Reset sets the nonmaskable mask until software enables the interrupt.
// - A line still low when its mask clears is recognised at once.
// - Mode taken from mode pins during reset; lower pins pulled down in reset.
`ifndef RSTSEQ_MAP_SVH
`define RSTSEQ_MAP_SVH
`define OSC_DELAY_CYC    4096
`define RECOVER_LOW_CYC  16
`define SAMPLE_DLY_CYC   9
`define VEC_NORMAL       16'hFFFE
`define VEC_CLKMON       16'hFFFC
`define VEC_WDOG         16'hFFFA
`define ADDR_INT_CTRL    4'h0
`define ADDR_PULLUP_CTRL 4'h1
`define ADDR_COND_CODE   4'h2
`define ADDR_STATUS      4'h3
`define ADDR_MODE        4'h4
`define INT_CTRL_RST     8'h40
`define INT_CTRL_EDGE    7
`define INT_CTRL_EN      6
`define PULLUP_CTRL_RST  8'h10
`define PULLUP_EN_BIT    4
`define COND_CODE_RST    8'hD0
`define CC_X_BIT         6
`define CC_I_BIT         4
`endif

// [hdl/rstseq_pkg.sv]
package rstseq_pkg;
  typedef enum logic [2:0] {
    SEQ_OSC, SEQ_LOW, SEQ_WAIT, SEQ_RUN
  } seq_state_type;
  typedef enum logic [1:0] {
    SRC_NORMAL, SRC_CLKMON, SRC_WDOG
  } vec_src_type;
endpackage

// [hdl/sync_2ff.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for pin levels
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic             core_clk, // Clock
  input  wire logic             rst,      // Sync reset
  input  wire logic [WIDTH-1:0] din,      // Async level
  output logic      [WIDTH-1:0] dout      // Synchronised level
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;

  // Only stage two reads stage one
  always_comb begin
    nxt_stage1 = din;
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1_ff <= INIT;
      stage2_ff <= INIT;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign dout = stage2_ff;
endmodule

// [hdl/irq_detect.sv]
`timescale 1ns/1ps
`include "rstseq_map.svh"
// Maskable request qualifier: level or falling edge
module irq_detect (
  input  wire logic core_clk,  // Clock
  input  wire logic rst,       // Sync reset
  input  wire logic irqLvlN,   // Synchronised pin, active low
  input  wire logic edgeMode,  // 1 = falling edge
  input  wire logic enable,    // Input enable
  input  wire logic masked,    // Condition-code mask
  input  wire logic ack,       // Request acknowledged
  output logic      req        // Request to core
);
  logic prevN_ff;
  logic edgeHit_ff;
  logic nxt_prevN;
  logic nxt_edgeHit;

  // Edge latch: a new edge wins over an acknowledge in the same cycle
  always_comb begin
    nxt_prevN   = irqLvlN;
    nxt_edgeHit = edgeHit_ff;
    if (ack || !edgeMode) nxt_edgeHit = 1'b0;
    if (edgeMode && enable && prevN_ff && !irqLvlN) nxt_edgeHit = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prevN_ff   <= 1'b1;
      edgeHit_ff <= 1'b0;
    end else begin
      prevN_ff   <= nxt_prevN;
      edgeHit_ff <= nxt_edgeHit;
    end
  end

  // Level held low is seen again as soon as the mask drops
  assign req = enable && !masked && (edgeMode ? edgeHit_ff : !irqLvlN);

  // Level request follows the line while enabled and unmasked
  property p_level_req;
    @(posedge core_clk) disable iff (rst)
    (enable && !edgeMode && !irqLvlN && !masked) |-> req;
  endproperty
  a_level_req: assert property (p_level_req)
    else $error("level request not raised");
  property p_mask_blocks;
    @(posedge core_clk) disable iff (rst)
    masked |-> !req;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked request passed");
  // A falling edge is kept even when an acknowledge lands with it
  property p_edge_latch;
    @(posedge core_clk) disable iff (rst)
    (edgeMode && enable && prevN_ff && !irqLvlN) |=> edgeHit_ff;
  endproperty
  a_edge_latch: assert property (p_edge_latch)
    else $error("falling edge lost");
endmodule

// [testbench/ext_reset_model.sv]
`timescale 1ns/1ps
// Board side: reset circuit with slow pull-up and interlocked request sources
module ext_reset_model #(
  parameter int RISE_CYC = 3, // Pin rise time, kept under nine cycles
  parameter int ACK_LAG  = 6  // Slow source release after acknowledge
) (
  input  wire logic core_clk,     // Clock
  input  wire logic resetPinOut,  // Device drive value
  input  wire logic resetPinOeN,  // Low while device drives
  input  wire logic holdLow,      // Board pulls reset low
  output logic      resetPinIn,   // Reset pin level
  input  wire logic irqRaise,     // Maskable source request pulse
  input  wire logic nmiRaise,     // Nonmaskable source request pulse
  input  wire logic intAck,       // Acknowledge from core
  output logic      maskIntPinIn, // Maskable line
  output logic      nmiPinIn      // Nonmaskable line
);
  int   riseCnt = 0;
  int   lagCnt  = 0;
  logic irqHold = 1'h0;
  logic nmiHold = 1'h0;
  logic pulled;

  // Wired level: any low driver wins, pull-up needs a few cycles to lift it
  assign pulled = (!resetPinOeN && !resetPinOut) || holdLow;
  assign resetPinIn = pulled ? 1'h0 : (riseCnt == 0);
  always @(posedge core_clk) begin
    if (pulled) riseCnt <= RISE_CYC;
    else if (riseCnt > 0) riseCnt <= riseCnt - 1;
  end

  // Sources hold their line low until acknowledged, and let go late
  always @(posedge core_clk) begin
    if (irqRaise) irqHold <= 1'h1;
    if (nmiRaise) nmiHold <= 1'h1;
    if (intAck) lagCnt <= ACK_LAG;
    else if (lagCnt > 0) lagCnt <= lagCnt - 1;
    if (lagCnt == 1) begin
      irqHold <= 1'h0;
      nmiHold <= 1'h0;
    end
  end
  assign maskIntPinIn = !irqHold;
  assign nmiPinIn     = !nmiHold;
endmodule

// [testbench/test_reset_sequencer.sv]
`timescale 1ns/1ps
`include "rstseq_map.svh"
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin numErrors++; \
  $display("Error at %0t ns: got %0h expected %0h", $time, got, exp); end end
module test_reset_sequencer;
  import rstseq_pkg::*;
  localparam int OSC = 8; // Short oscillator delay keeps the run brief
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } row_type;
  // Reset values, read-back, unmapped place
  row_type rows [8] = '{'{1'h0, 4'h0, 8'h00, 8'h40}, '{1'h0, 4'h1, 8'h00, 8'h10},
    '{1'h0, 4'h2, 8'h00, 8'hD0}, '{1'h0, 4'h3, 8'h00, 8'h18}, '{1'h1, 4'h5, 8'hFF, 8'h00},
    '{1'h0, 4'hF, 8'h00, 8'h00}, '{1'h1, 4'h0, 8'h80, 8'h80}, '{1'h1, 4'h0, 8'h40, 8'h40}};
  logic core_clk, rst, wdogTimeout, wdogEn, clkFail, clkMonEn, resetPinIn, resetPinOut;
  logic resetPinOeN, coreReset, maskIntPinIn, nmiPinIn, pullupOn, modeSelA, modeSelB;
  logic specialModeN, modePulldown, maskIntReq, nmiReq, intAck, regWr, regRd;
  logic holdLow, irqRaise, nmiRaise;
  logic [15:0] vectorAddr;
  logic [2:0]  opMode;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata, rd;
  int          numErrors = 0;
  int          comparisons = 0;

  reset_sequencer #(.OSC_DELAY(OSC)) reset_sequencer_i (.core_clk(core_clk), .rst(rst),
    .wdogTimeout(wdogTimeout), .wdogEn(wdogEn), .clkFail(clkFail), .clkMonEn(clkMonEn),
    .resetPinIn(resetPinIn), .resetPinOut(resetPinOut), .resetPinOeN(resetPinOeN),
    .coreReset(coreReset), .vectorAddr(vectorAddr), .maskIntPinIn(maskIntPinIn),
    .nmiPinIn(nmiPinIn), .pullupOn(pullupOn), .modeSelA(modeSelA), .modeSelB(modeSelB),
    .specialModeN(specialModeN), .modePulldown(modePulldown), .opMode(opMode),
    .maskIntReq(maskIntReq), .nmiReq(nmiReq), .intAck(intAck), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  ext_reset_model ext_reset_model_i (.core_clk(core_clk), .resetPinOut(resetPinOut),
    .resetPinOeN(resetPinOeN), .holdLow(holdLow), .resetPinIn(resetPinIn),
    .irqRaise(irqRaise), .nmiRaise(nmiRaise), .intAck(intAck),
    .maskIntPinIn(maskIntPinIn), .nmiPinIn(nmiPinIn));

  task automatic giveVerdict;
    $display("Comparisons: %0d, errors: %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'h0;
    #1 d = regRdata;
  endtask
  task automatic raise(input logic nmi);
    @(posedge core_clk);
    if (nmi) nmiRaise <= 1'h1;
    else irqRaise <= 1'h1;
    @(posedge core_clk);
    nmiRaise <= 1'h0;
    irqRaise <= 1'h0;
  endtask
  task automatic ack;
    @(posedge core_clk);
    intAck <= 1'h1;
    @(posedge core_clk);
    intAck <= 1'h0;
  endtask
  // One-cycle event pulse on watchdog and/or clock monitor
  task automatic fire(input logic wd, input logic cm);
    @(posedge core_clk);
    wdogTimeout <= wd;
    clkFail <= cm;
    @(posedge core_clk);
    wdogTimeout <= 1'h0;
    clkFail <= 1'h0;
    #1;
  endtask
  // Count drive-low and released cycles until the core runs
  task automatic recover(input int lowExp, input logic [15:0] vec);
    int lowCyc = 0;
    int relCyc = 0;
    while (coreReset !== 1'h0 && lowCyc + relCyc < 300) begin
      if (resetPinOeN === 1'h0) lowCyc++;
      else relCyc++;
      tick(1);
    end
    `CHECK(lowCyc >= lowExp && lowCyc <= lowExp + 1, 1'h1)
    `CHECK(relCyc >= 9 && relCyc <= 10, 1'h1)
    `CHECK(vectorAddr, vec)
  endtask

  // Free-running 50 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge core_clk);
    numErrors++;
    giveVerdict();
  end
  // Main sequence
  initial begin
    {rst, wdogEn, clkMonEn, modeSelB} <= 4'hF;
    {wdogTimeout, clkFail, modeSelA, specialModeN, intAck, regWr, regRd} <= 7'h00;
    {holdLow, irqRaise, nmiRaise, regAddr, regWdata} <= 15'h0000;
    repeat (16) @(posedge core_clk);
    #1;
    `CHECK({resetPinOut, resetPinOeN, coreReset, modePulldown, pullupOn}, 5'h07)
    @(posedge core_clk);
    rst <= 1'h0;
    #1;
    recover(OSC + 16, `VEC_NORMAL);
    `CHECK({opMode, modePulldown}, 4'h4)
    for (int i = 0; i < 8; i++) begin
      if (rows[i].wr) regWrite(rows[i].addr, rows[i].data);
      regRead(rows[i].addr, rd);
      `CHECK(rd, rows[i].exp)
    end
    // Masks set by reset, then lifted while lines are still low
    raise(1'h0);
    raise(1'h1);
    tick(5);
    `CHECK({maskIntReq, nmiReq}, 2'h0)
    regWrite(4'h2, 8'h90);
    tick(2);
    `CHECK({maskIntReq, nmiReq}, 2'h1)
    regWrite(4'h2, 8'h80);
    tick(2);
    `CHECK(maskIntReq, 1'h1)
    ack();
    tick(2);
    `CHECK(maskIntReq, 1'h1)
    tick(10);
    `CHECK({maskIntReq, nmiReq}, 2'h0)
    // Edge mode drops the request on acknowledge although the line stays low
    regWrite(4'h0, 8'hC0);
    raise(1'h0);
    tick(4);
    `CHECK(maskIntReq, 1'h1)
    ack();
    tick(2);
    `CHECK(maskIntReq, 1'h0)
    tick(10);
    regWrite(4'h0, 8'h00);
    raise(1'h0);
    tick(5);
    `CHECK(maskIntReq, 1'h0)
    ack();
    tick(10);
    regWrite(4'h1, 8'h00);
    tick(1);
    `CHECK(pullupOn, 1'h0)
    regWrite(4'h2, 8'hD0);
    regRead(4'h2, rd);
    `CHECK(rd, 8'h90)
    // Disabled watchdog is ignored
    @(posedge core_clk);
    wdogEn <= 1'h0;
    fire(1'h1, 1'h0);
    tick(3);
    `CHECK(coreReset, 1'h0)
    @(posedge core_clk);
    wdogEn <= 1'h1;
    {modeSelA, modeSelB, specialModeN} <= 3'h5;
    fire(1'h1, 1'h0);
    recover(16, `VEC_WDOG);
    `CHECK({opMode, pullupOn}, 4'hB)
    regRead(4'h3, rd);
    `CHECK(rd, 8'h18)
    fire(1'h1, 1'h1);
    recover(OSC + 16, `VEC_CLKMON);
    // Board holds the pin low across a watchdog reset
    @(posedge core_clk);
    holdLow <= 1'h1;
    fire(1'h1, 1'h0);
    // Watchdog is latched, yet the low pin must give the normal vector
    for (int i = 0; i < 300 && coreReset !== 1'h0; i++) tick(1);
    `CHECK({coreReset, vectorAddr}, {1'h0, `VEC_NORMAL})
    @(posedge core_clk);
    holdLow <= 1'h0;
    #1;
    `CHECK(coreReset, 1'h1)
    for (int i = 0; i < 300 && coreReset !== 1'h0; i++) tick(1);
    `CHECK({coreReset, vectorAddr}, {1'h0, `VEC_NORMAL})
    regRead(4'h3, rd);
    `CHECK(rd, 8'h18)
    // Power-on reset again in mid-run brings back the startup delay
    @(posedge core_clk);
    rst <= 1'h1;
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    #1;
    recover(OSC + 16, `VEC_NORMAL);
    giveVerdict();
  end
endmodule
